// file: rtl/cqo_consts.svh
`ifndef CQO_CONSTS_SVH
`define CQO_CONSTS_SVH
`define CQO_RT_MEM_RD 4'h0
`define CQO_RT_MEM_WR 4'h1
`define CQO_RT_IO_RD 4'h2
`define CQO_RT_IO_WR 4'h3
`define CQO_RT_LOCK_RD 4'h7
`define CQO_RT_MSG 4'hC
`define CQO_RT_VDM 4'hD
`define CQO_RT_ATS 4'hE
`define CQO_DESC_W 128
`define CQO_DESC_DW_MASK 4'hF
`define CQO_F_AT 1:0
`define CQO_F_ADDR 63:2
`define CQO_F_ADDR_HI 63:32
`define CQO_F_DWCNT 74:64
`define CQO_F_TYPE 78:75
`define CQO_F_RSV79 79
`define CQO_F_REQID 95:80
`define CQO_F_TAG 103:96
`define CQO_F_FUNC 111:104
`define CQO_F_FUNC_HI 111:107
`define CQO_F_BAR 114:112
`define CQO_F_APER 120:115
`define CQO_F_TC 123:121
`define CQO_F_ATTR 126:124
`define CQO_F_IDO 126
`define CQO_F_RSV127 127
`define CQO_DW_ONE 11'h001
`define CQO_FUNC_LEGACY_MASK 8'h07
`define CQO_SB_FBE 3:0
`define CQO_SB_LBE 7:4
`define CQO_SB_SOP 8
`define CQO_SB_W 9
`define CQO_REG_CTRL 5'h00
`define CQO_REG_STATUS 5'h04
`define CQO_REG_CQCNT 5'h08
`define CQO_REG_TAG 5'h0C
`define CQO_CTRL_ARI 0
`define CQO_ST_POSTED 0
`define CQO_ST_CQ_BUSY 1
`define CQO_ST_RC_BUSY 2
`define CQO_ST_TX_BUSY 3
`endif

// file: rtl/cqo_pkg.sv
package cqo_pkg;
	typedef enum logic [1:0] {CQ_IDLE, CQ_DESC, CQ_PAY} cqo_cq_state_e;
	typedef enum logic [1:0] {LAY_MEM, LAY_VDM, LAY_ATS, LAY_MSG} cqo_layout_e;
	typedef enum logic [1:0] {TX_NONE, TX_RQ, TX_CC} cqo_tx_src_e;
endpackage

// file: rtl/cqo_top.sv
// Functional notes
// - completion waits for earlier posted TLPs delivered
// - relaxed or ID-ordered completion may overtake posted
// - each transmit port keeps its own order
// - tag shown once request cannot be passed
// - request and completion ports independent, width 64/128/256
// - one packet per request, 16-byte descriptor first
// - descriptor two beats at 64, else one
// - four descriptor layouts chosen by request kind
// - address translation bits in 1:0
// - address in 63:2, upper zero if 32-bit
// - Dword count in 74:64, I/O is 1
// - zero-length memory: count 1, first enables zero
// - request type code in 78:75
// - requester ID in 95:80
// - target function 111:104, ARI gates upper bits
// - BAR number in 114:112
// - BAR aperture in 120:115
// - traffic class 123:121, attributes 126:124
// - request type code values
// - byte enables and sop valid in first beat
`timescale 1ns/1ps
`include "cqo_consts.svh"
module cqo_top
	import cqo_pkg::*;
#(
	parameter int DATA_W = 256,
	parameter int CNT_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic hdr_valid_i,
	output logic hdr_ready_o,
	input wire logic [3:0] hdr_type_i,
	input wire logic [61:0] hdr_addr_dw_i,
	input wire logic hdr_addr64_i,
	input wire logic [1:0] hdr_at_i,
	input wire logic [10:0] hdr_dwords_i,
	input wire logic hdr_zero_len_i,
	input wire logic [15:0] hdr_req_id_i,
	input wire logic [7:0] hdr_tag_i,
	input wire logic [7:0] hdr_func_i,
	input wire logic [2:0] hdr_bar_i,
	input wire logic [5:0] hdr_aperture_i,
	input wire logic [2:0] hdr_tc_i,
	input wire logic [2:0] hdr_attr_i,
	input wire logic [3:0] hdr_first_byte_enables_i,
	input wire logic [3:0] hdr_last_be_i,
	input wire logic hdr_has_payload_i,
	input wire logic [DATA_W-1:0] pl_tdata_i,
	input wire logic [DATA_W/32-1:0] pl_tkeep_i,
	input wire logic pl_tlast_i,
	input wire logic pl_tvalid_i,
	output logic pl_tready_o,
	output logic [DATA_W-1:0] cq_tdata_o,
	output logic [DATA_W/32-1:0] cq_tkeep_o,
	output logic cq_tlast_o,
	output logic cq_tvalid_o,
	input wire logic cq_tready_i,
	output logic [`CQO_SB_W-1:0] completer_request_sideband_out_o,
	input wire logic [DATA_W-1:0] cpl_tdata_i,
	input wire logic cpl_tlast_i,
	input wire logic cpl_tvalid_i,
	input wire logic cpl_ro_i,
	input wire logic cpl_ido_i,
	input wire logic [15:0] cpl_id_i,
	output logic cpl_tready_o,
	output logic [DATA_W-1:0] rc_tdata_o,
	output logic rc_tlast_o,
	output logic rc_tvalid_o,
	input wire logic rc_tready_i,
	input wire logic [DATA_W-1:0] rq_tdata_i,
	input wire logic rq_tlast_i,
	input wire logic rq_tvalid_i,
	input wire logic [3:0] request_port_sideband_in_i,
	output logic rq_tready_o,
	input wire logic [DATA_W-1:0] cc_tdata_i,
	input wire logic cc_tlast_i,
	input wire logic cc_tvalid_i,
	output logic cc_tready_o,
	output logic [DATA_W-1:0] tx_tdata_o,
	output logic tx_tlast_o,
	output logic tx_tvalid_o,
	input wire logic tx_tready_i,
	output logic [3:0] request_order_tag_out_o,
	output logic request_order_tag_valid_o
);
	localparam int KEEP_W = DATA_W / 32;
	localparam int DESC_BEATS = (DATA_W >= `CQO_DESC_W) ? 1 : `CQO_DESC_W / DATA_W;
	localparam int DX_W = (DATA_W > `CQO_DESC_W) ? DATA_W : `CQO_DESC_W;
	localparam logic [KEEP_W-1:0] DESC_KEEP = KEEP_W'(`CQO_DESC_DW_MASK);

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic ari_en;
	logic [CNT_W-1:0] cq_pkt_cnt;
	logic [3:0] last_tag;
	cqo_cq_state_e cq_state;
	cqo_layout_e next_layout;
	logic [`CQO_DESC_W-1:0] next_desc;
	logic [`CQO_DESC_W-1:0] desc_q;
	logic [DX_W-1:0] desc_ext;
	logic [3:0] next_fbe;
	logic [3:0] fbe_q;
	logic [3:0] lbe_q;
	logic is_io;
	logic is_zl;
	logic is_posted;
	logic pay_q;
	logic beat_q;
	logic desc_last;
	logic hdr_fire;
	logic pl_fire;
	logic cq_take;
	logic posted_inflight;
	logic [15:0] cur_rid;
	logic next_posted;
	logic [15:0] next_rid;
	logic next_blocked;
	logic rc_in_pkt;
	logic next_in_pkt;
	logic next_rc_valid;
	logic cpl_fire;
	logic rc_start;
	logic rc_take;
	cqo_tx_src_e tx_src;
	cqo_tx_src_e next_src;
	logic last_was_rq;
	logic pick_rq;
	logic next_tx_valid;
	logic rq_fire;
	logic cc_fire;
	logic tx_take;
	logic [3:0] tag_hold;

	// register bus: one wait cycle, then one answer cycle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
			if (avs_read_i && avs_waitrequest_o) begin
				avs_readdata_o <= 32'h0;
				unique case (avs_address_i)
					`CQO_REG_CTRL: avs_readdata_o[`CQO_CTRL_ARI] <= ari_en;
					`CQO_REG_STATUS: begin
						avs_readdata_o[`CQO_ST_POSTED] <= posted_inflight;
						avs_readdata_o[`CQO_ST_CQ_BUSY] <= cq_state != CQ_IDLE;
						avs_readdata_o[`CQO_ST_RC_BUSY] <= rc_in_pkt || rc_tvalid_o;
						avs_readdata_o[`CQO_ST_TX_BUSY] <= tx_src != TX_NONE || tx_tvalid_o;
					end
					`CQO_REG_CQCNT: avs_readdata_o[CNT_W-1:0] <= cq_pkt_cnt;
					`CQO_REG_TAG: avs_readdata_o[3:0] <= last_tag;
					default: avs_readdata_o <= 32'h0;
				endcase
			end
		end
	end

	a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("bus request not answered next cycle");

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ari_en <= 1'b0;
		end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == `CQO_REG_CTRL
			&& avs_byteenable_i[0]) begin
			ari_en <= avs_writedata_i[`CQO_CTRL_ARI];
		end
	end

	// descriptor builder
	always_comb begin
		next_desc = '0;
		is_io = hdr_type_i == `CQO_RT_IO_RD || hdr_type_i == `CQO_RT_IO_WR;
		is_zl = hdr_zero_len_i && (hdr_type_i == `CQO_RT_MEM_RD
			|| hdr_type_i == `CQO_RT_MEM_WR);
		is_posted = hdr_type_i == `CQO_RT_MEM_WR
			|| (hdr_type_i >= `CQO_RT_MSG && hdr_type_i <= `CQO_RT_ATS);
		if (hdr_type_i <= `CQO_RT_LOCK_RD) begin
			next_layout = LAY_MEM;
		end else if (hdr_type_i == `CQO_RT_VDM) begin
			next_layout = LAY_VDM;
		end else if (hdr_type_i == `CQO_RT_ATS) begin
			next_layout = LAY_ATS;
		end else begin
			next_layout = LAY_MSG;
		end
		next_desc[`CQO_F_TYPE] = hdr_type_i;
		next_desc[`CQO_F_DWCNT] = (is_io || is_zl) ? `CQO_DW_ONE : hdr_dwords_i;
		next_desc[`CQO_F_REQID] = hdr_req_id_i;
		next_desc[`CQO_F_TAG] = hdr_tag_i;
		next_desc[`CQO_F_TC] = hdr_tc_i;
		next_desc[`CQO_F_ATTR] = hdr_attr_i;
		if (is_io) begin
			next_desc[`CQO_F_IDO] = 1'b0;
		end
		next_fbe = is_zl ? 4'h0 : hdr_first_byte_enables_i;
		unique case (next_layout)
			LAY_MEM: begin
				next_desc[`CQO_F_ADDR] = hdr_addr_dw_i;
				if (!hdr_addr64_i) begin
					next_desc[`CQO_F_ADDR_HI] = 32'h0;
				end
				if (!is_io) begin
					next_desc[`CQO_F_AT] = hdr_at_i;
				end
				next_desc[`CQO_F_FUNC] = ari_en ? hdr_func_i
					: (hdr_func_i & `CQO_FUNC_LEGACY_MASK);
				next_desc[`CQO_F_BAR] = hdr_bar_i;
				next_desc[`CQO_F_APER] = hdr_aperture_i;
			end
			// message-specific fields stay zero
			LAY_VDM, LAY_ATS, LAY_MSG: begin
				next_desc[`CQO_F_RSV127] = 1'b0;
			end
		endcase
	end

	assign hdr_fire = hdr_valid_i && hdr_ready_o;
	assign pl_fire = pl_tvalid_i && pl_tready_o;
	assign cq_take = cq_tvalid_o && cq_tready_i;
	assign desc_ext = DX_W'(desc_q);
	assign desc_last = beat_q == 1'(DESC_BEATS - 1);

	// completer request packet sequencer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cq_state <= CQ_IDLE;
			hdr_ready_o <= 1'b0;
			pl_tready_o <= 1'b0;
			desc_q <= '0;
			fbe_q <= 4'h0;
			lbe_q <= 4'h0;
			pay_q <= 1'b0;
			beat_q <= 1'b0;
			cq_tvalid_o <= 1'b0;
			cq_tdata_o <= '0;
			cq_tkeep_o <= '0;
			cq_tlast_o <= 1'b0;
			completer_request_sideband_out_o <= '0;
		end else begin
			unique case (cq_state)
				CQ_IDLE: begin
					hdr_ready_o <= !hdr_fire;
					if (hdr_fire) begin
						desc_q <= next_desc;
						fbe_q <= next_fbe;
						lbe_q <= hdr_last_be_i;
						pay_q <= hdr_has_payload_i;
						beat_q <= 1'b0;
						cq_state <= CQ_DESC;
					end
				end
				CQ_DESC: begin
					if (!cq_tvalid_o) begin
						cq_tvalid_o <= 1'b1;
						cq_tdata_o <= desc_ext[beat_q*DATA_W +: DATA_W];
						cq_tkeep_o <= DESC_KEEP;
						cq_tlast_o <= desc_last && !pay_q;
						completer_request_sideband_out_o <= '0;
						if (!beat_q) begin
							completer_request_sideband_out_o[`CQO_SB_FBE] <= fbe_q;
							completer_request_sideband_out_o[`CQO_SB_LBE] <= lbe_q;
							completer_request_sideband_out_o[`CQO_SB_SOP] <= 1'b1;
						end
					end else if (cq_take) begin
						cq_tvalid_o <= 1'b0;
						if (!desc_last) begin
							beat_q <= 1'b1;
						end else if (pay_q) begin
							cq_state <= CQ_PAY;
							pl_tready_o <= 1'b1;
						end else begin
							cq_state <= CQ_IDLE;
							hdr_ready_o <= 1'b1;
						end
					end
				end
				CQ_PAY: begin
					if (pl_fire) begin
						pl_tready_o <= 1'b0;
						cq_tvalid_o <= 1'b1;
						cq_tdata_o <= pl_tdata_i;
						cq_tkeep_o <= pl_tkeep_i;
						cq_tlast_o <= pl_tlast_i;
						completer_request_sideband_out_o <= '0;
					end else if (cq_take) begin
						cq_tvalid_o <= 1'b0;
						if (cq_tlast_o) begin
							cq_state <= CQ_IDLE;
							hdr_ready_o <= 1'b1;
						end else begin
							pl_tready_o <= 1'b1;
						end
					end
				end
				default: cq_state <= CQ_IDLE;
			endcase
		end
	end

	a_io_count: assert property (cq_state == CQ_DESC && (desc_q[`CQO_F_TYPE] == `CQO_RT_IO_RD
		|| desc_q[`CQO_F_TYPE] == `CQO_RT_IO_WR) |-> desc_q[`CQO_F_DWCNT] == `CQO_DW_ONE)
		else $error("io request count not one");
	a_zero_len: assert property (hdr_fire && is_zl |=> desc_q[`CQO_F_DWCNT] == `CQO_DW_ONE
		&& fbe_q == 4'h0) else $error("zero-length request misreported");
	a_addr_32bit: assert property (hdr_fire && !hdr_addr64_i |=> desc_q[`CQO_F_ADDR_HI] == 32'h0)
		else $error("32-bit address has upper bits");
	a_rsv_zero: assert property (cq_state == CQ_DESC |-> !desc_q[`CQO_F_RSV127]
		&& !desc_q[`CQO_F_RSV79]) else $error("reserved descriptor bit set");
	a_func_legacy: assert property (hdr_fire && !ari_en |=> desc_q[`CQO_F_FUNC_HI] == 5'h00)
		else $error("function upper bits set without ari");
	a_sop_first: assert property (cq_tvalid_o && completer_request_sideband_out_o[`CQO_SB_SOP]
		|-> cq_state == CQ_DESC && !beat_q) else $error("sop outside first beat");
	a_desc_end: assert property (cq_take && cq_state == CQ_DESC && desc_last && !pay_q
		|-> cq_tlast_o ##1 (!cq_tvalid_o && hdr_ready_o)) else $error("descriptor end wrong");

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cq_pkt_cnt <= '0;
		end else if (cq_take && cq_tlast_o) begin
			cq_pkt_cnt <= cq_pkt_cnt + 1'b1;
		end
	end

	// posted tracking, set wins over clear
	always_comb begin
		next_posted = posted_inflight;
		next_rid = cur_rid;
		if (cq_take && cq_tlast_o) begin
			next_posted = 1'b0;
		end
		if (hdr_fire && is_posted) begin
			next_posted = 1'b1;
			next_rid = hdr_req_id_i;
		end
		next_blocked = next_posted && !(cpl_ro_i || (cpl_ido_i && cpl_id_i != next_rid));
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			posted_inflight <= 1'b0;
			cur_rid <= 16'h0;
		end else begin
			posted_inflight <= next_posted;
			cur_rid <= next_rid;
		end
	end

	// requester completion forwarding
	assign cpl_fire = cpl_tvalid_i && cpl_tready_o;
	assign rc_start = cpl_fire && !rc_in_pkt;
	assign rc_take = rc_tvalid_o && rc_tready_i;
	assign next_rc_valid = cpl_fire || (rc_tvalid_o && !rc_take);
	assign next_in_pkt = cpl_fire ? !cpl_tlast_i : rc_in_pkt;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpl_tready_o <= 1'b0;
			rc_in_pkt <= 1'b0;
			rc_tvalid_o <= 1'b0;
			rc_tdata_o <= '0;
			rc_tlast_o <= 1'b0;
		end else begin
			// new packet granted only on a held valid, so its attributes are the ones checked
			cpl_tready_o <= !next_rc_valid
				&& (next_in_pkt || (cpl_tvalid_i && !next_blocked));
			rc_in_pkt <= next_in_pkt;
			rc_tvalid_o <= next_rc_valid;
			if (cpl_fire) begin
				rc_tdata_o <= cpl_tdata_i;
				rc_tlast_o <= cpl_tlast_i;
			end
		end
	end

	a_cpl_hold: assert property (rc_start |-> !posted_inflight || cpl_ro_i
		|| (cpl_ido_i && cpl_id_i != cur_rid)) else $error("completion passed posted");

	// transmit merge of request and completion streams
	assign rq_fire = rq_tvalid_i && rq_tready_o;
	assign cc_fire = cc_tvalid_i && cc_tready_o;
	assign tx_take = tx_tvalid_o && tx_tready_i;
	assign next_tx_valid = rq_fire || cc_fire || (tx_tvalid_o && !tx_take);
	assign pick_rq = rq_tvalid_i && (!cc_tvalid_i || !last_was_rq);

	always_comb begin
		next_src = tx_src;
		if (rq_fire) begin
			next_src = rq_tlast_i ? TX_NONE : TX_RQ;
		end else if (cc_fire) begin
			next_src = cc_tlast_i ? TX_NONE : TX_CC;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_src <= TX_NONE;
			last_was_rq <= 1'b0;
			rq_tready_o <= 1'b0;
			cc_tready_o <= 1'b0;
			tx_tvalid_o <= 1'b0;
			tx_tdata_o <= '0;
			tx_tlast_o <= 1'b0;
		end else begin
			tx_src <= next_src;
			rq_tready_o <= !next_tx_valid && (next_src == TX_RQ
				|| (next_src == TX_NONE && pick_rq));
			cc_tready_o <= !next_tx_valid && (next_src == TX_CC
				|| (next_src == TX_NONE && !pick_rq && cc_tvalid_i));
			tx_tvalid_o <= next_tx_valid;
			if (rq_fire) begin
				last_was_rq <= 1'b1;
				tx_tdata_o <= rq_tdata_i;
				tx_tlast_o <= rq_tlast_i;
			end else if (cc_fire) begin
				last_was_rq <= 1'b0;
				tx_tdata_o <= cc_tdata_i;
				tx_tlast_o <= cc_tlast_i;
			end
		end
	end

	a_tx_no_mix: assert property (tx_src == TX_RQ |-> !cc_fire)
		else $error("completion interleaved into request");
	a_tx_no_mix_cc: assert property (tx_src == TX_CC |-> !rq_fire)
		else $error("request interleaved into completion");

	// order tag: shown when the last request beat is in the merged stream
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tag_hold <= 4'h0;
			last_tag <= 4'h0;
			request_order_tag_out_o <= 4'h0;
			request_order_tag_valid_o <= 1'b0;
		end else begin
			request_order_tag_valid_o <= rq_fire && rq_tlast_i;
			if (rq_fire && tx_src == TX_NONE) begin
				tag_hold <= request_port_sideband_in_i;
			end
			if (rq_fire && rq_tlast_i) begin
				request_order_tag_out_o <= (tx_src == TX_NONE) ? request_port_sideband_in_i
					: tag_hold;
				last_tag <= (tx_src == TX_NONE) ? request_port_sideband_in_i : tag_hold;
			end
		end
	end

	a_tag_after_req: assert property (request_order_tag_valid_o |-> $past(rq_fire && rq_tlast_i)
		&& tx_tvalid_o && tx_tlast_o) else $error("order tag before request merged");
endmodule // cqo_top

// file: verif/cqo_user_model.sv
`timescale 1ns/1ps
module cqo_user_model
	import cqo_pkg::*;
#(
	parameter int DATA_W = 64
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] mode_i,
	input wire logic [DATA_W-1:0] cq_tdata_i,
	input wire logic [DATA_W/32-1:0] cq_tkeep_i,
	input wire logic cq_tlast_i,
	input wire logic cq_tvalid_i,
	input wire logic [8:0] cq_side_i,
	output logic cq_tready_o,
	input wire logic [DATA_W-1:0] rc_tdata_i,
	input wire logic rc_tlast_i,
	input wire logic rc_tvalid_i,
	output logic rc_tready_o,
	input wire logic [DATA_W-1:0] tx_tdata_i,
	input wire logic tx_tlast_i,
	input wire logic tx_tvalid_i,
	output logic tx_tready_o
);
	logic [DATA_W+DATA_W/32+9:0] cq_q[$];
	logic [DATA_W:0] rc_q[$];
	logic [DATA_W:0] tx_q[$];
	logic phase;
	// mode 0 prompt, 1 slow on every port, 2 completer request port stalled
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase <= 1'b0;
			cq_tready_o <= 1'b0;
			rc_tready_o <= 1'b0;
			tx_tready_o <= 1'b0;
		end else begin
			phase <= ~phase;
			cq_tready_o <= (mode_i == 2'h2) ? 1'b0 : ((mode_i == 2'h1) ? phase : 1'b1);
			rc_tready_o <= (mode_i == 2'h1) ? ~phase : 1'b1;
			tx_tready_o <= (mode_i == 2'h1) ? phase : 1'b1;
			if (cq_tvalid_i && cq_tready_o)
				cq_q.push_back({cq_side_i, cq_tlast_i, cq_tkeep_i, cq_tdata_i});
			if (rc_tvalid_i && rc_tready_o)
				rc_q.push_back({rc_tlast_i, rc_tdata_i});
			if (tx_tvalid_i && tx_tready_o)
				tx_q.push_back({tx_tlast_i, tx_tdata_i});
		end
	end
endmodule // cqo_user_model

// file: verif/cqo_top_tb_top.sv
`timescale 1ns/1ps
`include "cqo_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
`define WAIT(c) do @(posedge ref_clk_i); while (!(c));
`define UM i_cqo_user_model
module cqo_top_tb_top
	import cqo_pkg::*;
;
	localparam int DW = 64;
	localparam logic [61:0] ADDR = 62'h0BAD_CAFE_1234_5678;
	localparam logic [15:0] RID = 16'h1A2B;
	localparam logic [DW-1:0] PLD = 64'hC0DE_0000_1111_2222;
	localparam logic [DW-1:0] CPD = 64'hC1C1_0000_3333_4444;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, d32;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic avs_waitrequest_o, hdr_ready_o, pl_tready_o, cq_tlast_o, cq_tvalid_o, cpl_tready_o;
	logic rc_tlast_o, rc_tvalid_o, rq_tready_o, cc_tready_o, tx_tlast_o, tx_tvalid_o;
	logic request_order_tag_valid_o, cq_tready_i, rc_tready_i, tx_tready_i;
	logic hdr_valid_i = 1'b0, hdr_addr64_i = 1'b0, hdr_zero_len_i = 1'b0, hdr_has_payload_i = 1'b0;
	logic pl_tlast_i = 1'b1, pl_tvalid_i = 1'b0, cpl_tlast_i = 1'b1, cpl_tvalid_i = 1'b0;
	logic cpl_ro_i = 1'b0, cpl_ido_i = 1'b0, rq_tlast_i = 1'b0, rq_tvalid_i = 1'b0;
	logic cc_tlast_i = 1'b1, cc_tvalid_i = 1'b0;
	logic [3:0] hdr_type_i = 4'h0, request_port_sideband_in_i = 4'h0, request_order_tag_out_o;
	logic [61:0] hdr_addr_dw_i = ADDR;
	logic [1:0] hdr_at_i = 2'h2, mode = 2'h0;
	logic [10:0] hdr_dwords_i = 11'h005;
	logic [15:0] hdr_req_id_i = RID, cpl_id_i = RID;
	logic [7:0] hdr_tag_i = 8'h3C, hdr_func_i = 8'hA5;
	logic [2:0] hdr_bar_i = 3'h4, hdr_tc_i = 3'h5, hdr_attr_i = 3'h7;
	logic [5:0] hdr_aperture_i = 6'h0C;
	logic [3:0] hdr_first_byte_enables_i = 4'hE, hdr_last_be_i = 4'h7;
	logic [DW-1:0] pl_tdata_i = PLD, cq_tdata_o, cpl_tdata_i = CPD, rc_tdata_o;
	logic [DW-1:0] rq_tdata_i = 64'h0, cc_tdata_i = 64'h0, tx_tdata_o;
	logic [DW/32-1:0] pl_tkeep_i = 2'h3, cq_tkeep_o;
	logic [`CQO_SB_W-1:0] completer_request_sideband_out_o;
	logic [DW+DW/32+9:0] e;
	logic [DW:0] r;
	logic [3:0] tag_seen[$];
	int i, j, err_count = 0, comparisons = 0;
	logic [3:0] typ[11] = '{`CQO_RT_MEM_RD, `CQO_RT_MEM_WR, `CQO_RT_IO_RD, `CQO_RT_IO_WR, 4'h4,
		4'h5, 4'h6, `CQO_RT_LOCK_RD, `CQO_RT_MSG, `CQO_RT_VDM, `CQO_RT_ATS};
	logic ro_t[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic ido_t[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic pas_t[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	logic [15:0] id_t[4] = '{RID, RID, 16'h0F0F, RID};

	cqo_top #(.DATA_W(DW)) i_cqo_top (.*);
	cqo_user_model #(.DATA_W(DW)) i_cqo_user_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.mode_i(mode), .cq_tdata_i(cq_tdata_o), .cq_tkeep_i(cq_tkeep_o), .cq_tlast_i(cq_tlast_o),
		.cq_tvalid_i(cq_tvalid_o), .cq_side_i(completer_request_sideband_out_o),
		.cq_tready_o(cq_tready_i), .rc_tdata_i(rc_tdata_o), .rc_tlast_i(rc_tlast_o),
		.rc_tvalid_i(rc_tvalid_o), .rc_tready_o(rc_tready_i), .tx_tdata_i(tx_tdata_o),
		.tx_tlast_i(tx_tlast_o), .tx_tvalid_i(tx_tvalid_o), .tx_tready_o(tx_tready_i));

	initial forever #4 ref_clk_i = ~ref_clk_i;

	task automatic complete_run;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic avs_acc(input logic wr, input logic [4:0] a, input logic [31:0] v,
		input logic [3:0] be);
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= v;
		avs_byteenable_i <= be;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		`WAIT(avs_waitrequest_o === 1'b0)
		d32 = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	function automatic logic [127:0] exp_desc(input logic [3:0] t, input logic a64,
		input logic zl, input logic ari);
		logic [127:0] d;
		logic io;
		d = '0;
		io = (t == `CQO_RT_IO_RD) || (t == `CQO_RT_IO_WR);
		if (t <= `CQO_RT_LOCK_RD) begin
			d[63:2] = ADDR;
			if (!a64)
				d[63:32] = 32'h0;
			if (!io)
				d[1:0] = 2'h2;
			d[111:104] = ari ? 8'hA5 : 8'h05;
			d[114:112] = 3'h4;
			d[120:115] = 6'h0C;
		end
		d[74:64] = (io || zl) ? 11'h001 : 11'h005;
		d[78:75] = t;
		d[95:80] = RID;
		d[103:96] = 8'h3C;
		d[123:121] = 3'h5;
		d[126:124] = io ? 3'h3 : 3'h7;
		return d;
	endfunction

	task automatic send_pkt(input logic [3:0] t, input logic a64, input logic zl, input logic pl);
		@(posedge ref_clk_i);
		hdr_type_i <= t;
		hdr_addr64_i <= a64;
		hdr_zero_len_i <= zl;
		hdr_dwords_i <= zl ? 11'h000 : 11'h005;
		hdr_has_payload_i <= pl;
		hdr_valid_i <= 1'b1;
		`WAIT(hdr_ready_o === 1'b1)
		hdr_valid_i <= 1'b0;
		if (pl) begin
			pl_tvalid_i <= 1'b1;
			`WAIT(pl_tready_o === 1'b1)
			pl_tvalid_i <= 1'b0;
		end
	endtask

	task automatic check_pkt(input logic [3:0] t, input logic a64, input logic zl,
		input logic pl, input logic ari);
		logic [127:0] d;
		d = exp_desc(t, a64, zl, ari);
		`WAIT(`UM.cq_q.size() >= 2 + int'(pl))
		e = `UM.cq_q.pop_front();
		`CHK(e, {1'b1, 4'h7, zl ? 4'h0 : 4'hE, 1'b0, 2'h3, d[63:0]})
		e = `UM.cq_q.pop_front();
		`CHK(e, {9'h000, ~pl, 2'h3, d[127:64]})
		if (pl) begin
			e = `UM.cq_q.pop_front();
			`CHK(e, {9'h000, 1'b1, 2'h3, PLD})
		end
	endtask

	task automatic send_cpl(input logic ro, input logic ido, input logic [15:0] id);
		@(posedge ref_clk_i);
		cpl_ro_i <= ro;
		cpl_ido_i <= ido;
		cpl_id_i <= id;
		cpl_tvalid_i <= 1'b1;
		`WAIT(cpl_tready_o === 1'b1)
		cpl_tvalid_i <= 1'b0;
	endtask

	task automatic send_rq(input logic [3:0] tg, input logic [DW-1:0] b);
		@(posedge ref_clk_i);
		request_port_sideband_in_i <= tg;
		for (int k = 0; k < 2; k++) begin
			rq_tdata_i <= b + DW'(k);
			rq_tlast_i <= (k == 1);
			rq_tvalid_i <= 1'b1;
			`WAIT(rq_tready_o === 1'b1)
		end
		rq_tvalid_i <= 1'b0;
	endtask

	always @(posedge ref_clk_i) begin
		if (rst_n_i && request_order_tag_valid_o === 1'b1) begin
			tag_seen.push_back(request_order_tag_out_o);
			`CHK({tx_tvalid_o, tx_tlast_o}, 2'h3)
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_count++;
		$display("ERROR %0t: watchdog expired", $time);
		complete_run;
	end

	initial begin
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 5; i++) begin
			avs_acc(1'b0, 5'(i * 4), 32'h0, 4'hF);
			`CHK(d32, 32'h0)
		end
		$display("test register reset done");
		for (i = 0; i < 11; i++) begin
			send_pkt(typ[i], i[0], 1'b0, typ[i] == `CQO_RT_MEM_WR);
			check_pkt(typ[i], i[0], 1'b0, typ[i] == `CQO_RT_MEM_WR, 1'b0);
		end
		send_pkt(`CQO_RT_MEM_WR, 1'b1, 1'b1, 1'b1);
		check_pkt(`CQO_RT_MEM_WR, 1'b1, 1'b1, 1'b1, 1'b0);
		$display("test descriptors done");
		avs_acc(1'b1, 5'h00, 32'h1, 4'hF);
		avs_acc(1'b1, 5'h00, 32'h0, 4'hE);
		avs_acc(1'b1, 5'h10, 32'h1, 4'hF);
		avs_acc(1'b0, 5'h00, 32'h0, 4'hF);
		`CHK(d32, 32'h1)
		send_pkt(`CQO_RT_MEM_RD, 1'b1, 1'b0, 1'b0);
		check_pkt(`CQO_RT_MEM_RD, 1'b1, 1'b0, 1'b0, 1'b1);
		$display("test wide function done");
		for (i = 0; i < 4; i++) begin
			mode <= 2'h2;
			send_pkt(`CQO_RT_MEM_WR, 1'b0, 1'b0, 1'b0);
			fork
				send_cpl(ro_t[i], ido_t[i], id_t[i]);
				begin
					repeat (20) @(posedge ref_clk_i);
					`CHK(`UM.rc_q.size(), int'(pas_t[i]))
					avs_acc(1'b0, 5'h04, 32'h0, 4'hF);
					`CHK(d32, 32'h3)
					mode <= 2'h0;
					`WAIT(`UM.rc_q.size() == 1)
					if (!pas_t[i])
						`CHK(`UM.cq_q.size(), 2)
				end
			join
			`WAIT(`UM.cq_q.size() == 2)
			`UM.cq_q.delete();
			r = `UM.rc_q.pop_front();
			`CHK(r, {1'b1, CPD})
		end
		$display("test completion ordering done");
		mode <= 2'h1;
		fork
			begin
				send_rq(4'h5, 64'hA0);
				send_rq(4'h6, 64'hB0);
			end
			begin
				`WAIT(tag_seen.size() > 0)
				cc_tdata_i <= 64'hCC;
				cc_tvalid_i <= 1'b1;
				`WAIT(cc_tready_o === 1'b1)
				cc_tvalid_i <= 1'b0;
			end
			begin
				`WAIT(tag_seen.size() > 1)
				`CHK(tag_seen[1], 4'h6)
			end
		join
		`WAIT(`UM.tx_q.size() == 5)
		// let the tag monitor sample the same edge first
		@(posedge ref_clk_i);
		`CHK(`UM.tx_q[0], {1'b0, 64'hA0})
		`CHK(`UM.tx_q[1], {1'b1, 64'hA1})
		j = (`UM.tx_q[2] === {1'b1, 64'hCC}) ? 3 : 2;
		`CHK(`UM.tx_q[j], {1'b0, 64'hB0})
		`CHK(`UM.tx_q[j + 1], {1'b1, 64'hB1})
		`CHK(`UM.tx_q[(j == 3) ? 2 : 4], {1'b1, 64'hCC})
		`CHK(tag_seen.size(), 2)
		`CHK(tag_seen[0], 4'h5)
		`CHK(tag_seen[1], 4'h6)
		avs_acc(1'b0, 5'h0C, 32'h0, 4'hF);
		`CHK(d32, 32'h6)
		avs_acc(1'b0, 5'h08, 32'h0, 4'hF);
		`CHK(d32, 32'h11)
		$display("test transmit order done");
		complete_run;
	end
endmodule // cqo_top_tb_top
